// file: logic/lehw_regs.svh
`ifndef LEHW_REGS_SVH
`define LEHW_REGS_SVH

// clock period and the fixed channel sample window
`define LEHW_CLK_NS      100
`define LEHW_SAMPLE_NS   2000
`define LEHW_SAMPLE_CYC  ((`LEHW_SAMPLE_NS + `LEHW_CLK_NS - 1) / `LEHW_CLK_NS)

// widths
`define LEHW_TW          16
`define LEHW_SEQ_W       8
`define LEHW_RETRY_W     4

// reset values
`define LEHW_SEQ_RST     8'h00

`endif

// file: logic/lehw_pkg.sv
package lehw_pkg;

  typedef enum logic [2:0] {
    LEHW_K_DATA   = 3'h0,
    LEHW_K_ACK    = 3'h1,
    LEHW_K_DREQ   = 3'h2,
    LEHW_K_WAKEUP = 3'h3,
    LEHW_K_BEACON = 3'h4
  } lehw_kind_t;

  typedef struct packed {
    lehw_kind_t  kind;
    logic [7:0]  seq;
    logic        pending;
    logic        bcast;
    logic        dst_match;
    logic [15:0] remain;
  } lehw_rx_frame_t;

  typedef struct packed {
    lehw_kind_t  kind;
    logic [7:0]  seq;
    logic        pending;
    logic        bcast;
    logic        ack_req;
    logic [15:0] remain;
  } lehw_tx_frame_t;

  typedef enum logic [15:0] {
    LEHW_S_IDLE     = 16'h0001,
    LEHW_S_EP_SLEEP = 16'h0002,
    LEHW_S_EP_TX    = 16'h0004,
    LEHW_S_EP_ACKW  = 16'h0008,
    LEHW_S_EP_DREQ  = 16'h0010,
    LEHW_S_EP_DATAW = 16'h0020,
    LEHW_S_EP_SAMP  = 16'h0040,
    LEHW_S_EP_BSLP  = 16'h0080,
    LEHW_S_EP_ACKTX = 16'h0100,
    LEHW_S_CO_LIST  = 16'h0200,
    LEHW_S_CO_TXW   = 16'h0400,
    LEHW_S_CO_CCA   = 16'h0800,
    LEHW_S_CO_WAKE  = 16'h1000,
    LEHW_S_CO_WGAP  = 16'h2000,
    LEHW_S_CO_DATA  = 16'h4000,
    LEHW_S_CO_ACKW  = 16'h8000
  } lehw_state_t;

endpackage

// file: logic/lehw_timer.sv
`timescale 1ns/1ns
`include "lehw_regs.svh"
module lehw_timer
  import lehw_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        load,
  input  wire logic [15:0] value,
  input  wire logic        stop,
  output logic             running,
  output logic             expired,
  output logic [15:0]      remain
);
  logic [15:0] next_remain;
  logic        next_expired;

  always_comb begin
    next_remain  = remain;
    next_expired = 1'b0;
    if (load) begin
      // a zero load still lasts one cycle
      next_remain = (value == 16'h0000) ? 16'h0001 : value;
    end else if (stop) begin
      next_remain = 16'h0000;
    end else if (remain != 16'h0000) begin
      next_remain  = remain - 16'h0001;
      next_expired = (remain == 16'h0001);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      remain  <= 16'h0000;
      expired <= 1'b0;
    end else begin
      remain  <= next_remain;
      expired <= next_expired;
    end
  end

  assign running = (remain != 16'h0000);
endmodule

// file: logic/lehw_retry.sv
`timescale 1ns/1ns
`include "lehw_regs.svh"
module lehw_retry
  import lehw_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       clear,
  input  wire logic       bump,
  input  wire logic [3:0] max_retry_count,
  output logic            exhausted,
  output logic [3:0]      count
);
  logic [3:0] next_count;

  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = 4'h0;
    end else if (bump && count != 4'hf) begin
      next_count = count + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count <= 4'h0;
    end else begin
      count <= next_count;
    end
  end

  assign exhausted = (count >= max_retry_count);
endmodule

// file: logic/lehw_mac.sv
// What this block does
// - low-energy mode runs only if enabled and both sampling periods are zero.
// - coordinator listens always, except while transmitting any frame or in its wakeup and data-send states.
// - endpoint sleeps, enables transmitter only for a queued frame, a data request or an ack, then sends it.
// - endpoint uses slotted access with superframe support, unslotted otherwise.
// - coordinator acks endpoint data and data requests while listening, pending set only if it holds unicast data.
// - endpoint waits ack time for matching sequence, else retransmits up to max.
// - pending ack makes endpoint request data; data pending bit keeps receiver on.
// - wakeup listening mode follows its enable and ignores the two period attributes.
// - coordinator listens except while sending and precedes urgent data with wakeup frames.
// - wakeups spaced by the spacing attribute, listen between, sequence length limited.
// - endpoint samples only at a period end in LEHW_S_EP_SLEEP with no frame queued, which restarts the period; with no wakeup it turns receiver off.
// - own-address unicast wakeup: stop sampling, send data request, wait data time.
// - data request after unicast wakeup stops sequence; data sent at once, ack awaited.
// - endpoint acks unicast data; repeated wakeup resends data request up to max retries.
// - with several frames queued, pending set in every unicast data frame except the last.
// - coordinator gains channel first; skips wakeups inside pending window after pending.
// - coordinator sends data, retransmits without ack, loops while data remains.
// - broadcast wakeups carry broadcast address and time left before the data frame.
// - endpoint on broadcast wakeup stops sampling, requests, sleeps remaining time, listens.
// - broadcast wakeups run until all requested or limit, data at announced time.
`timescale 1ns/1ns
`include "lehw_regs.svh"
module lehw_mac
  import lehw_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            resetn,
  input  wire logic            is_coordinator,
  input  wire logic            low_energy_enable_attr,
  input  wire logic [15:0]     coordinated_sampling_period_attr,
  input  wire logic [15:0]     receiver_initiated_period_attr,
  input  wire logic            wakeup_listen_enable_attr,
  input  wire logic            low_energy_superframe_flag,
  input  wire logic [15:0]     ack_wait_time,
  input  wire logic [3:0]      max_retry_count,
  input  wire logic [15:0]     wakeup_frame_spacing,
  input  wire logic [15:0]     wakeup_sequence_limit,
  input  wire logic [15:0]     channel_sample_period,
  input  wire logic [15:0]     data_wait_time,
  input  wire logic [15:0]     pending_skip_window,
  input  wire logic            ul_frame_ready,
  input  wire logic            dl_unicast_ready,
  input  wire logic            dl_bcast_ready,
  input  wire logic            dl_more_frames,
  input  wire logic            dl_ack_request,
  input  wire logic            all_requested,
  input  wire logic            beacon_due,
  input  wire logic            rx_valid,
  input  wire lehw_rx_frame_t  rx_frame,
  input  wire logic            tx_done,
  input  wire logic            channel_acquired,
  output lehw_tx_frame_t       tx_frame,
  output logic                 tx_start,
  output logic                 tx_on,
  output logic                 rx_on,
  output logic                 slotted_access,
  output logic                 le_mode_active,
  output logic                 wakeup_mode_active,
  output logic                 stop_sampling,
  output logic                 xfer_ok,
  output logic                 xfer_fail
);
  lehw_state_t    state, next_state;
  lehw_tx_frame_t next_tx_frame;
  logic [7:0]     seq, next_seq;
  logic           next_tx_start, next_tx_on, next_rx_on, next_stop_sampling;
  logic           next_xfer_ok, next_xfer_fail, next_le_mode_active, next_wakeup_mode_active;
  logic           bcast_op, next_bcast_op;
  logic           last_pend, next_last_pend;
  logic           rx_pend, next_rx_pend;
  logic           sampling, next_sampling;
  logic [15:0]    bc_remain, next_bc_remain;
  logic           g_load, s_load, p_load, s_stop;
  logic [15:0]    g_val, p_val;
  logic           g_exp, s_run, s_exp, p_run, p_exp;
  logic [15:0]    s_left;
  logic           r_clear, r_bump, r_exh;
  logic           le_ok, hw_ok, ack_match;

  lehw_timer u_gen (.sys_clk(sys_clk), .resetn(resetn), .load(g_load), .value(g_val), .stop(1'b0),
                    .running(), .expired(g_exp), .remain());
  lehw_timer u_seq (.sys_clk(sys_clk), .resetn(resetn), .load(s_load), .value(wakeup_sequence_limit),
                    .stop(s_stop), .running(s_run), .expired(s_exp), .remain(s_left));
  lehw_timer u_per (.sys_clk(sys_clk), .resetn(resetn), .load(p_load), .value(p_val), .stop(1'b0),
                    .running(p_run), .expired(p_exp), .remain());
  lehw_retry u_rty (.sys_clk(sys_clk), .resetn(resetn), .clear(r_clear), .bump(r_bump),
                    .max_retry_count(max_retry_count), .exhausted(r_exh), .count());

  function automatic lehw_tx_frame_t mk_frame(input lehw_kind_t k, input logic [7:0] s, input logic p,
                                              input logic b, input logic a, input logic [15:0] r);
    lehw_tx_frame_t f;
    f.kind    = k;
    f.seq     = s;
    f.pending = p;
    f.bcast   = b;
    f.ack_req = a;
    f.remain  = r;
    return f;
  endfunction

  always_comb begin
    le_ok = low_energy_enable_attr && coordinated_sampling_period_attr == 16'h0000
            && receiver_initiated_period_attr == 16'h0000;
    hw_ok = wakeup_listen_enable_attr;
    ack_match = rx_valid && rx_frame.kind == LEHW_K_ACK && rx_frame.seq == seq;
    next_state = state;
    next_tx_frame = tx_frame;
    next_seq = seq;
    next_tx_start = 1'b0;
    next_stop_sampling = 1'b0;
    next_xfer_ok = 1'b0;
    next_xfer_fail = 1'b0;
    next_bcast_op = bcast_op;
    next_last_pend = last_pend;
    next_rx_pend = rx_pend;
    next_sampling = sampling;
    next_bc_remain = bc_remain;
    next_le_mode_active = le_ok;
    next_wakeup_mode_active = hw_ok;
    g_load = 1'b0;
    g_val = ack_wait_time;
    s_load = 1'b0;
    s_stop = 1'b0;
    p_load = 1'b0;
    p_val = channel_sample_period;
    r_clear = 1'b0;
    r_bump = 1'b0;
    case (state)
      LEHW_S_IDLE: begin
        if (le_ok || hw_ok) begin
          next_state = is_coordinator ? LEHW_S_CO_LIST : LEHW_S_EP_SLEEP;
        end
        next_sampling = hw_ok;
        p_load = hw_ok;
      end
      LEHW_S_EP_SLEEP: begin
        if (!(le_ok || hw_ok)) begin
          next_state = LEHW_S_IDLE;
        end else if (ul_frame_ready) begin
          next_seq = seq + 8'h01;
          next_tx_frame = mk_frame(LEHW_K_DATA, seq + 8'h01, 1'b0, 1'b0, 1'b1, 16'h0000);
          next_tx_start = 1'b1;
          r_clear = 1'b1;
          next_state = LEHW_S_EP_TX;
        end else if (sampling && hw_ok && p_exp) begin
          p_load = 1'b1;
          g_load = 1'b1;
          g_val = 16'(`LEHW_SAMPLE_CYC);
          next_state = LEHW_S_EP_SAMP;
        end
      end
      LEHW_S_EP_TX: begin
        if (tx_done) begin
          g_load = 1'b1;
          next_state = LEHW_S_EP_ACKW;
        end
      end
      LEHW_S_EP_ACKW: begin
        if (ack_match) begin
          next_xfer_ok = 1'b1;
          if (rx_frame.pending) begin
            next_bcast_op = 1'b0;
            next_seq = seq + 8'h01;
            next_tx_frame = mk_frame(LEHW_K_DREQ, seq + 8'h01, 1'b0, 1'b0, 1'b1, 16'h0000);
            next_tx_start = 1'b1;
            r_clear = 1'b1;
            next_state = LEHW_S_EP_DREQ;
          end else begin
            next_state = LEHW_S_EP_SLEEP;
          end
        end else if (g_exp) begin
          if (r_exh) begin
            next_xfer_fail = 1'b1;
            next_state = LEHW_S_EP_SLEEP;
          end else begin
            r_bump = 1'b1;
            next_tx_start = 1'b1;
            next_state = LEHW_S_EP_TX;
          end
        end
      end
      LEHW_S_EP_SAMP: begin
        if (rx_valid && rx_frame.kind == LEHW_K_WAKEUP && (rx_frame.bcast || rx_frame.dst_match)) begin
          next_stop_sampling = 1'b1;
          next_sampling = 1'b0;
          next_bcast_op = rx_frame.bcast;
          next_bc_remain = rx_frame.remain;
          next_seq = seq + 8'h01;
          next_tx_frame = mk_frame(LEHW_K_DREQ, seq + 8'h01, 1'b0, 1'b0, 1'b1, 16'h0000);
          next_tx_start = 1'b1;
          r_clear = 1'b1;
          next_state = LEHW_S_EP_DREQ;
        end else if (g_exp) begin
          next_state = LEHW_S_EP_SLEEP;
        end
      end
      LEHW_S_EP_DREQ: begin
        if (tx_done) begin
          g_load = 1'b1;
          g_val = bcast_op ? bc_remain : data_wait_time;
          next_state = bcast_op ? LEHW_S_EP_BSLP : LEHW_S_EP_DATAW;
        end
      end
      LEHW_S_EP_BSLP: begin
        if (g_exp) begin
          g_load = 1'b1;
          g_val = data_wait_time;
          next_state = LEHW_S_EP_DATAW;
        end
      end
      LEHW_S_EP_DATAW: begin
        if (rx_valid && rx_frame.kind == LEHW_K_DATA) begin
          next_rx_pend = rx_frame.pending;
          if (rx_frame.bcast) begin
            next_xfer_ok = 1'b1;
            next_sampling = hw_ok;
            next_state = LEHW_S_EP_SLEEP;
          end else begin
            next_tx_frame = mk_frame(LEHW_K_ACK, rx_frame.seq, 1'b0, 1'b0, 1'b0, 16'h0000);
            next_tx_start = 1'b1;
            next_state = LEHW_S_EP_ACKTX;
          end
        end else if (rx_valid && rx_frame.kind == LEHW_K_WAKEUP && rx_frame.dst_match && !rx_frame.bcast) begin
          if (r_exh) begin
            next_xfer_fail = 1'b1;
            next_sampling = hw_ok;
            next_state = LEHW_S_EP_SLEEP;
          end else begin
            r_bump = 1'b1;
            next_tx_frame = mk_frame(LEHW_K_DREQ, seq, 1'b0, 1'b0, 1'b1, 16'h0000);
            next_tx_start = 1'b1;
            next_state = LEHW_S_EP_DREQ;
          end
        end else if (g_exp) begin
          next_sampling = hw_ok;
          next_state = LEHW_S_EP_SLEEP;
        end
      end
      LEHW_S_EP_ACKTX: begin
        if (tx_done) begin
          next_xfer_ok = 1'b1;
          g_load = 1'b1;
          g_val = data_wait_time;
          // listen on for the retry wakeup or the next pending frame
          next_state = LEHW_S_EP_DATAW;
          if (!rx_pend && !hw_ok) begin
            next_state = LEHW_S_EP_SLEEP;
          end
        end
      end
      LEHW_S_CO_LIST: begin
        if (!(le_ok || hw_ok)) begin
          next_state = LEHW_S_IDLE;
        end else if (rx_valid && (rx_frame.kind == LEHW_K_DATA || rx_frame.kind == LEHW_K_DREQ)) begin
          next_tx_frame = mk_frame(LEHW_K_ACK, rx_frame.seq, dl_unicast_ready, 1'b0, 1'b0, 16'h0000);
          next_tx_start = 1'b1;
          next_state = LEHW_S_CO_TXW;
        end else if (low_energy_superframe_flag && beacon_due) begin
          next_tx_frame = mk_frame(LEHW_K_BEACON, seq, 1'b0, 1'b0, 1'b0, 16'h0000);
          next_tx_start = 1'b1;
          next_state = LEHW_S_CO_TXW;
        end else if (hw_ok && (dl_unicast_ready || dl_bcast_ready)) begin
          next_bcast_op = !dl_unicast_ready;
          r_clear = 1'b1;
          next_state = LEHW_S_CO_CCA;
        end
      end
      LEHW_S_CO_TXW: begin
        if (tx_done) begin
          next_state = LEHW_S_CO_LIST;
        end
      end
      LEHW_S_CO_CCA: begin
        if (channel_acquired) begin
          if (!bcast_op && last_pend && p_run) begin
            next_state = LEHW_S_CO_DATA;
          end else begin
            s_load = 1'b1;
            next_state = LEHW_S_CO_WAKE;
          end
        end
      end
      LEHW_S_CO_WAKE: begin
        next_tx_frame = mk_frame(LEHW_K_WAKEUP, seq, 1'b0, bcast_op, 1'b0, s_left);
        next_tx_start = 1'b1;
        next_state = LEHW_S_CO_WGAP;
        g_load = 1'b1;
        g_val = wakeup_frame_spacing;
      end
      LEHW_S_CO_WGAP: begin
        if (!bcast_op && rx_valid && rx_frame.kind == LEHW_K_DREQ) begin
          s_stop = 1'b1;
          next_state = LEHW_S_CO_DATA;
        end else if (s_exp || !s_run) begin
          next_state = LEHW_S_CO_DATA;
        end else if (g_exp && !(bcast_op && all_requested)) begin
          next_state = LEHW_S_CO_WAKE;
        end
      end
      LEHW_S_CO_DATA: begin
        if (!tx_on) begin
          next_seq = seq + 8'h01;
          next_tx_frame = mk_frame(LEHW_K_DATA, seq + 8'h01, !bcast_op && dl_more_frames, bcast_op,
                                   !bcast_op && dl_ack_request, 16'h0000);
          next_tx_start = 1'b1;
        end else if (tx_done) begin
          if (tx_frame.ack_req) begin
            g_load = 1'b1;
            next_state = LEHW_S_CO_ACKW;
          end else begin
            next_xfer_ok = 1'b1;
            next_state = LEHW_S_CO_LIST;
          end
        end
      end
      LEHW_S_CO_ACKW: begin
        if (ack_match) begin
          next_xfer_ok = 1'b1;
          next_last_pend = tx_frame.pending;
          p_load = 1'b1;
          p_val = pending_skip_window;
          r_clear = 1'b1;
          next_state = dl_unicast_ready ? LEHW_S_CO_CCA : LEHW_S_CO_LIST;
        end else if (g_exp) begin
          if (r_exh) begin
            next_xfer_fail = 1'b1;
            next_state = LEHW_S_CO_LIST;
          end else begin
            r_bump = 1'b1;
            next_tx_start = 1'b1;
            next_state = LEHW_S_CO_DATA;
          end
        end
      end
      default: begin
        next_state = LEHW_S_IDLE;
      end
    endcase
    next_tx_on = (next_tx_start || tx_on) && !tx_done;
    // awake endpoint states and coordinator states other than LEHW_S_CO_WAKE and LEHW_S_CO_DATA listen whenever not sending
    next_rx_on = !next_tx_on && (next_state == LEHW_S_CO_LIST || next_state == LEHW_S_CO_CCA
                 || next_state == LEHW_S_CO_WGAP || next_state == LEHW_S_CO_ACKW || next_state == LEHW_S_CO_TXW
                 || next_state == LEHW_S_EP_ACKW || next_state == LEHW_S_EP_DATAW
                 || next_state == LEHW_S_EP_SAMP);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state              <= LEHW_S_IDLE;
      tx_frame           <= '0;
      seq                <= `LEHW_SEQ_RST;
      tx_start           <= 1'b0;
      tx_on              <= 1'b0;
      rx_on              <= 1'b0;
      slotted_access     <= 1'b0;
      le_mode_active     <= 1'b0;
      wakeup_mode_active <= 1'b0;
      stop_sampling      <= 1'b0;
      xfer_ok            <= 1'b0;
      xfer_fail          <= 1'b0;
      bcast_op           <= 1'b0;
      last_pend          <= 1'b0;
      rx_pend            <= 1'b0;
      sampling           <= 1'b0;
      bc_remain          <= 16'h0000;
    end else begin
      state              <= next_state;
      tx_frame           <= next_tx_frame;
      seq                <= next_seq;
      tx_start           <= next_tx_start;
      tx_on              <= next_tx_on;
      rx_on              <= next_rx_on;
      slotted_access     <= low_energy_superframe_flag;
      le_mode_active     <= next_le_mode_active;
      wakeup_mode_active <= next_wakeup_mode_active;
      stop_sampling      <= next_stop_sampling;
      xfer_ok            <= next_xfer_ok;
      xfer_fail          <= next_xfer_fail;
      bcast_op           <= next_bcast_op;
      last_pend          <= next_last_pend;
      rx_pend            <= next_rx_pend;
      sampling           <= next_sampling;
      bc_remain          <= next_bc_remain;
    end
  end
endmodule

// file: testbench/lehw_mac_monitor.sv
`timescale 1ns/1ns
module lehw_mac_monitor
  import lehw_pkg::*;
(
  input wire logic           sys_clk,
  input wire logic           resetn,
  input wire logic           is_coordinator,
  input wire logic           low_energy_enable_attr,
  input wire logic [15:0]    coordinated_sampling_period_attr,
  input wire logic [15:0]    receiver_initiated_period_attr,
  input wire logic           wakeup_listen_enable_attr,
  input wire logic           low_energy_superframe_flag,
  input wire logic           dl_unicast_ready,
  input wire logic           rx_valid,
  input wire lehw_rx_frame_t rx_frame,
  input wire logic           tx_done,
  input wire lehw_tx_frame_t tx_frame,
  input wire logic           tx_start,
  input wire logic           tx_on,
  input wire logic           rx_on,
  input wire logic           slotted_access,
  input wire logic           le_mode_active,
  input wire logic           wakeup_mode_active,
  input wire logic           xfer_ok,
  input wire logic           xfer_fail
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_le_entry;
    $rose(le_mode_active) |-> $past(low_energy_enable_attr) && $past(coordinated_sampling_period_attr) == 16'h0
      && $past(receiver_initiated_period_attr) == 16'h0;
  endproperty
  a_le_entry: assert property (p_le_entry) else $error("low-energy mode entered while blocked");
  property p_wake_entry; $rose(wakeup_mode_active) |-> $past(wakeup_listen_enable_attr); endproperty
  a_wake_entry: assert property (p_wake_entry) else $error("wakeup mode without enable");
  // vacuous at the first edge after release
  property p_slotted; $past(resetn) |-> slotted_access == $past(low_energy_superframe_flag); endproperty
  a_slotted: assert property (p_slotted) else $error("slotted access does not follow flag");
  property p_tx_on; tx_start |=> tx_on; endproperty
  a_tx_on: assert property (p_tx_on) else $error("transmitter not on after start");
  property p_tx_end; $fell(tx_on) |-> $past(tx_done); endproperty
  a_tx_end: assert property (p_tx_end) else $error("transmitter off before frame done");
  property p_ack;
    is_coordinator && le_mode_active && !wakeup_listen_enable_attr && rx_on && rx_valid && rx_frame.kind == LEHW_K_DATA
      |=> tx_start && tx_frame.kind == LEHW_K_ACK && tx_frame.seq == $past(rx_frame.seq)
      && tx_frame.pending == $past(dl_unicast_ready);
  endproperty
  a_ack: assert property (p_ack) else $error("endpoint data not acknowledged correctly");
  property p_ep_ok; xfer_ok && !is_coordinator |-> $past(rx_valid || tx_done); endproperty
  a_ep_ok: assert property (p_ep_ok) else $error("endpoint success without received frame");
  property p_wake_src; tx_start && tx_frame.kind == LEHW_K_WAKEUP |-> is_coordinator && wakeup_mode_active; endproperty
  a_wake_src: assert property (p_wake_src) else $error("wakeup frame outside coordinator wakeup mode");
  c_ok: cover property (xfer_ok);
  c_fail: cover property (xfer_fail);
  c_wake: cover property (tx_start && tx_frame.kind == LEHW_K_WAKEUP);
endmodule

// file: testbench/lehw_peer.sv
`timescale 1ns/1ns
module lehw_peer
  import lehw_pkg::*;
(
  input  wire logic           sys_clk,
  input  wire logic           tx_start,
  input  wire lehw_tx_frame_t tx_frame,
  input  wire logic           ack_en,
  input  wire logic           inj,
  input  wire lehw_rx_frame_t inj_frame,
  output logic                tx_done,
  output logic                rx_valid,
  output lehw_rx_frame_t      rx_frame
);
  int             t_cnt = 0;
  int             a_cnt = 0;
  lehw_tx_frame_t sent = '0;
  initial begin
    tx_done = 1'b0;
    rx_valid = 1'b0;
    rx_frame = '0;
  end
  always @(posedge sys_clk) begin
    tx_done <= 1'b0;
    rx_valid <= 1'b0;
    // idle channel shows a toggling pattern, the last frame and its inverse in turn
    rx_frame <= ~rx_frame;
    if (tx_start) begin
      sent <= tx_frame;
      t_cnt <= 4;
    end
    if (t_cnt > 0) t_cnt <= t_cnt - 1;
    if (t_cnt == 1) begin
      tx_done <= 1'b1;
      if (ack_en && sent.kind inside {LEHW_K_DATA, LEHW_K_DREQ}) a_cnt <= 3;
    end
    if (a_cnt > 0) a_cnt <= a_cnt - 1;
    if (a_cnt == 1) begin
      rx_valid <= 1'b1;
      rx_frame <= '{LEHW_K_ACK, sent.seq, 1'b0, 1'b0, 1'b1, 16'h0};
    end
    if (inj) begin
      rx_valid <= 1'b1;
      rx_frame <= inj_frame;
    end
  end
endmodule

// file: testbench/lehw_mac_tb.sv
`timescale 1ns/1ns
module lehw_mac_tb;
  import lehw_pkg::*;
  logic           sys_clk, resetn, is_coordinator, low_energy_enable_attr, wakeup_listen_enable_attr;
  logic           low_energy_superframe_flag, ul_frame_ready, dl_unicast_ready, dl_bcast_ready, dl_more_frames;
  logic           dl_ack_request, all_requested, beacon_due, channel_acquired, rx_valid, tx_done, tx_start;
  logic           tx_on, rx_on, slotted_access, le_mode_active, wakeup_mode_active, stop_sampling, xfer_ok;
  logic           xfer_fail, ack_en, inj;
  logic [3:0]     max_retry_count;
  logic [15:0]    coordinated_sampling_period_attr, receiver_initiated_period_attr, ack_wait_time;
  logic [15:0]    wakeup_frame_spacing, wakeup_sequence_limit, channel_sample_period, data_wait_time;
  logic [15:0]    pending_skip_window;
  lehw_rx_frame_t rx_frame, inj_frame;
  lehw_tx_frame_t tx_frame;
  logic [1:0]     ev;
  int             miscompares = 0;
  int             tests_run = 0;
  int             cyc = 0;
  int             n;
  assign ev = {xfer_ok, tx_start};
  lehw_mac uut (.*);
  lehw_peer peer (.*);
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  // bounded wait for a one-cycle pulse
  task automatic wait_ev(input int b);
    int k;
    k = 0;
    tick(1);
    while (ev[b] !== 1'b1 && k < 500) begin
      tick(1);
      k++;
    end
    chk("event", ev[b], 1'b1);
  endtask
  task automatic send_rx(input lehw_kind_t kind, input logic [7:0] seq);
    inj_frame = '{kind, seq, 1'b0, 1'b0, 1'b1, 16'h0};
    inj = 1'b1;
    tick(1);
    inj = 1'b0;
  endtask
  task automatic acquire();
    tick(3);
    channel_acquired = 1'b1;
    tick(1);
    channel_acquired = 1'b0;
  endtask
  task automatic do_reset();
    resetn = 1'b0;
    tick(5);
    resetn = 1'b1;
    tick(1);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    {resetn, is_coordinator, low_energy_enable_attr, wakeup_listen_enable_attr, low_energy_superframe_flag} = '0;
    {ul_frame_ready, dl_unicast_ready, dl_bcast_ready, dl_more_frames, all_requested, beacon_due} = '0;
    {channel_acquired, inj, inj_frame} = '0;
    {dl_ack_request, ack_en} = 2'h3;
    max_retry_count = 4'h2;
    coordinated_sampling_period_attr = 16'h5;
    receiver_initiated_period_attr = 16'h0;
    {ack_wait_time, wakeup_frame_spacing, wakeup_sequence_limit} = {16'h8, 16'h14, 16'hc8};
    {channel_sample_period, data_wait_time, pending_skip_window} = {16'h40, 16'h20, 16'h10};
    do_reset();
    chk("tx_start", tx_start, 1'b0);
    {low_energy_enable_attr, low_energy_superframe_flag} = 2'h3;
    tick(3);
    chk("le_blocked", le_mode_active, 1'b0);
    chk("slotted", slotted_access, 1'b1);
    coordinated_sampling_period_attr = 16'h0;
    tick(3);
    chk("le_on", le_mode_active, 1'b1);
    $display("test mode done");
    ul_frame_ready = 1'b1;
    wait_ev(0);
    ul_frame_ready = 1'b0;
    chk("ul_kind", tx_frame.kind, LEHW_K_DATA);
    wait_ev(1);
    $display("test uplink done");
    {ack_en, low_energy_superframe_flag, ul_frame_ready} = 3'h1;
    n = 0;
    repeat (300) begin
      tick(1);
      if (xfer_fail === 1'b1) break;
      n += tx_start;
    end
    {ack_en, ul_frame_ready} = 2'h2;
    chk("fail", xfer_fail, 1'b1);
    chk("attempts", n[15:0], 16'h3);
    chk("unslotted", slotted_access, 1'b0);
    $display("test retry done");
    is_coordinator = 1'b1;
    do_reset();
    tick(3);
    chk("co_rx_on", rx_on, 1'b1);
    for (int p = 0; p < 2; p++) begin
      dl_unicast_ready = p[0];
      send_rx(LEHW_K_DATA, 8'h40 + p[7:0]);
      wait_ev(0);
      chk("ack_kind", tx_frame.kind, LEHW_K_ACK);
      chk("ack_seq", tx_frame.seq, 8'h40 + p[7:0]);
      chk("ack_pend", tx_frame.pending, p[0]);
      tick(10);
    end
    $display("test coordinator ack done");
    wakeup_listen_enable_attr = 1'b1;
    coordinated_sampling_period_attr = 16'h7;
    tick(3);
    chk("wake_mode", wakeup_mode_active, 1'b1);
    acquire();
    wait_ev(0);
    chk("wake_kind", tx_frame.kind, LEHW_K_WAKEUP);
    tick(8);
    send_rx(LEHW_K_DREQ, 8'h50);
    wait_ev(0);
    if (tx_frame.kind === LEHW_K_ACK) wait_ev(0);
    chk("dl_kind", tx_frame.kind, LEHW_K_DATA);
    chk("dl_pend", tx_frame.pending, 1'b0);
    dl_unicast_ready = 1'b0;
    wait_ev(1);
    dl_bcast_ready = 1'b1;
    acquire();
    wait_ev(0);
    chk("bc_kind", tx_frame.kind, LEHW_K_WAKEUP);
    chk("bc_addr", tx_frame.bcast, 1'b1);
    chk("bc_remain", tx_frame.remain != 16'h0, 1'b1);
    dl_bcast_ready = 1'b0;
    $display("test wakeup done");
    complete_run();
  end
endmodule
bind lehw_mac lehw_mac_monitor mon (.*);
